// ==== rtl/monitor_readout_pkg.sv ====
// constants, field layout and carrier types of the monitor readout bank
// How it works
// - ext reg one packs four channel low bits
// - ext reg two bits 1:0 hold on-chip low bits
// - ext reg two bits 7:2 read zero
// - ext read freezes group until bytes read
// - either ext read freezes temperature group
// - three voltage upper bytes at consecutive addresses
// - two temperature upper bytes at consecutive addresses
// - timer upper bits zero below threshold
// - assertion sets timer bit zero
// - timer register read clears seen flag
// - past threshold, register is eight-bit count
// - each count is one fixed time step
// - second fan stall sets status bit zero
// - no stall flag while fan drive off
package monitor_readout_pkg;

  // register offsets
  localparam logic [7:0] ADDR_FAN_B_CFG   = 8'h06;
  localparam logic [7:0] ADDR_EXT_ONE     = 8'h08;
  localparam logic [7:0] ADDR_EXT_TWO     = 8'h09;
  localparam logic [7:0] ADDR_ANALOG_ONE  = 8'h0a;
  localparam logic [7:0] ADDR_ANALOG_TWO  = 8'h0b;
  localparam logic [7:0] ADDR_SUPPLY      = 8'h0c;
  localparam logic [7:0] ADDR_FAR_DIODE   = 8'h0d;
  localparam logic [7:0] ADDR_ONCHIP      = 8'h0e;
  localparam logic [7:0] ADDR_HOT_TIMER   = 8'h0f;
  localparam logic [7:0] ADDR_INT_STAT_ONE = 8'h10;

  // reset values
  localparam logic [7:0] FAN_B_CFG_RESET  = 8'h0c;
  localparam logic [7:0] READ_RESET       = 8'h00;

  // field positions
  localparam int EXT1_FAR_DIODE_LSB  = 0;
  localparam int EXT1_SUPPLY_LSB     = 2;
  localparam int EXT1_ANALOG_TWO_LSB = 4;
  localparam int EXT1_ANALOG_ONE_LSB = 6;
  localparam int EXT2_ONCHIP_LSB     = 0;
  localparam int HOT_SEEN_BIT        = 0;
  localparam int STAT1_FAN_B_BIT     = 0;

  // channel indices; voltage group first, then temperature group
  localparam int CH_ANALOG_ONE = 0;
  localparam int CH_ANALOG_TWO = 1;
  localparam int CH_SUPPLY     = 2;
  localparam int CH_FAR_DIODE  = 3;
  localparam int CH_ONCHIP     = 4;
  localparam int CH_COUNT      = 5;
  localparam int VOLT_CH_COUNT = 3;

  // timing
  localparam longint CLK_PERIOD_NS      = 100;
  localparam longint STEP_TIME_NS       = 22_760_000;
  localparam longint THRESH_TIME_NS     = 45_520_000;
  localparam int     STEP_CYCLES_DEFAULT = int'(STEP_TIME_NS / CLK_PERIOD_NS);
  localparam logic [7:0] THRESH_STEPS   = 8'(THRESH_TIME_NS / STEP_TIME_NS);
  localparam int     STEP_CNT_W         = 18;
  localparam logic [7:0] TMR_MAX        = 8'hff;

  typedef struct packed {
    logic       valid;
    logic [9:0] data;
  } conv_result_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

endpackage : monitor_readout_pkg

// ==== rtl/reading_hold.sv ====
// one conversion channel: latest result and the value shown to the host
`timescale 1ns/1ps
`default_nettype none
module reading_hold
  import monitor_readout_pkg::*;
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // conversion side
  input  wire conv_result_t conv,
  // freeze control
  input  wire logic         frozen,
  // shown value
  output logic [9:0]        shown
);

  logic [9:0] live_reg;
  logic [9:0] live_next;

  assign live_next = conv.valid ? conv.data : live_reg;

  // new results are always kept so the latest one is not lost while frozen
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      live_reg <= 10'h000;
    end else begin
      live_reg <= live_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      shown <= 10'h000;
    end else if (!frozen) begin
      shown <= live_next;
    end
  end

endmodule : reading_hold
`default_nettype wire

// ==== rtl/monitor_readout_regs.sv ====
// result register bank: readings, extended bits, hot timer, fan stall status
`timescale 1ns/1ps
`default_nettype none
module monitor_readout_regs
  import monitor_readout_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYCLES_DEFAULT
)
(
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  // register access
  input  wire host_req_t                   req,
  output logic [7:0]                       rd_data,
  output logic                             rd_valid,
  // conversion results
  input  wire conv_result_t [CH_COUNT-1:0] conv_in,
  // processor hot monitor
  input  wire logic                        processor_hot_input,
  // second fan
  input  wire logic                        fan_b_stall,
  input  wire logic                        fan_b_pwm_out,
  output logic [7:0]                       fan_b_cfg
);

  localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(STEP_CYCLES - 1);

  // read and write decode
  logic rd_ext_one;
  logic rd_ext_two;
  logic rd_hot;
  logic rd_stat;

  assign rd_ext_one = req.rd && (req.addr == ADDR_EXT_ONE);
  assign rd_ext_two = req.rd && (req.addr == ADDR_EXT_TWO);
  assign rd_hot     = req.rd && (req.addr == ADDR_HOT_TIMER);
  assign rd_stat    = req.rd && (req.addr == ADDR_INT_STAT_ONE);

  // freeze tracking: one pending bit per upper-byte register
  logic [2:0] volt_pend_reg;
  logic [1:0] temp_pend_reg;
  logic       volt_frozen;
  logic       temp_frozen;

  assign volt_frozen = |volt_pend_reg;
  assign temp_frozen = |temp_pend_reg;

  // hold from the taking edge on, so a result landing then cannot split the pair
  logic volt_hold;
  logic temp_hold;

  assign volt_hold = volt_frozen || rd_ext_one;
  assign temp_hold = temp_frozen || rd_ext_one || rd_ext_two;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      volt_pend_reg <= 3'h0;
    end else if (rd_ext_one) begin
      volt_pend_reg <= 3'h7;
    end else if (req.rd) begin
      // each upper-byte read releases its own bit; last one unfreezes
      if (req.addr == ADDR_ANALOG_ONE) begin
        volt_pend_reg[0] <= 1'b0;
      end
      if (req.addr == ADDR_ANALOG_TWO) begin
        volt_pend_reg[1] <= 1'b0;
      end
      if (req.addr == ADDR_SUPPLY) begin
        volt_pend_reg[2] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      temp_pend_reg <= 2'h0;
    end else if (rd_ext_one || rd_ext_two) begin
      temp_pend_reg <= 2'h3;
    end else if (req.rd) begin
      if (req.addr == ADDR_FAR_DIODE) begin
        temp_pend_reg[0] <= 1'b0;
      end
      if (req.addr == ADDR_ONCHIP) begin
        temp_pend_reg[1] <= 1'b0;
      end
    end
  end

  // shown readings, frozen per group
  logic [9:0] shown [CH_COUNT];

  for (genvar ch = 0; ch < CH_COUNT; ch++) begin : g_chan
    reading_hold u_hold (
      .mclk   (mclk),
      .rstn   (rstn),
      .conv   (conv_in[ch]),
      .frozen ((ch < VOLT_CH_COUNT) ? volt_hold : temp_hold),
      .shown  (shown[ch])
    );
  end

  // extended registers built from shown values, so they freeze too
  logic [7:0] ext_one;
  logic [7:0] ext_two;

  always_comb begin
    ext_one = READ_RESET;
    ext_one[EXT1_FAR_DIODE_LSB +: 2]  = shown[CH_FAR_DIODE][1:0];
    ext_one[EXT1_SUPPLY_LSB +: 2]     = shown[CH_SUPPLY][1:0];
    ext_one[EXT1_ANALOG_TWO_LSB +: 2] = shown[CH_ANALOG_TWO][1:0];
    ext_one[EXT1_ANALOG_ONE_LSB +: 2] = shown[CH_ANALOG_ONE][1:0];
  end

  always_comb begin
    ext_two = READ_RESET;
    ext_two[EXT2_ONCHIP_LSB +: 2] = shown[CH_ONCHIP][1:0];
  end

  // processor hot timer
  logic                  hot_prev_reg;
  logic                  hot_rise;
  logic                  seen_reg;
  logic [STEP_CNT_W-1:0] step_cnt_reg;
  logic [7:0]            tmr_reg;
  logic                  step_tick;
  logic [7:0]            hot_value;

  assign hot_rise  = processor_hot_input && !hot_prev_reg;
  assign step_tick = processor_hot_input && !hot_rise && (step_cnt_reg == STEP_LAST);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hot_prev_reg <= 1'b0;
    end else begin
      hot_prev_reg <= processor_hot_input;
    end
  end

  // a new assertion in the read cycle still leaves the flag set
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      seen_reg <= 1'b0;
    end else if (hot_rise) begin
      seen_reg <= 1'b1;
    end else if (rd_hot) begin
      seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      step_cnt_reg <= '0;
    end else if (!processor_hot_input || hot_rise || step_tick) begin
      step_cnt_reg <= '0;
    end else begin
      step_cnt_reg <= step_cnt_reg + 1'b1;
    end
  end

  // duration of the last assertion stays readable after it ends, if it reached THRESH_STEPS
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tmr_reg <= 8'h00;
    end else if (hot_rise) begin
      tmr_reg <= 8'h00;
    end else if (step_tick && (tmr_reg != TMR_MAX)) begin
      tmr_reg <= tmr_reg + 8'h01;
    end
  end

  always_comb begin
    hot_value = READ_RESET;
    hot_value[HOT_SEEN_BIT] = seen_reg;
    if (tmr_reg >= THRESH_STEPS) begin
      hot_value = tmr_reg;
    end
  end

  // second fan stall status, cleared by read only once the stall is gone
  logic stall_cond;
  logic stall_reg;

  assign stall_cond = fan_b_stall && fan_b_pwm_out;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stall_reg <= 1'b0;
    end else if (stall_cond) begin
      stall_reg <= 1'b1;
    end else if (rd_stat) begin
      stall_reg <= 1'b0;
    end
  end

  // fan config, the only writable register here
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fan_b_cfg <= FAN_B_CFG_RESET;
    end else if (req.wr && (req.addr == ADDR_FAN_B_CFG)) begin
      fan_b_cfg <= req.wdata;
    end
  end

  // read mux; unmapped addresses read zero
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = READ_RESET;
    case (req.addr)
      ADDR_FAN_B_CFG:    rd_mux = fan_b_cfg;
      ADDR_EXT_ONE:      rd_mux = ext_one;
      ADDR_EXT_TWO:      rd_mux = ext_two;
      ADDR_ANALOG_ONE:   rd_mux = shown[CH_ANALOG_ONE][9:2];
      ADDR_ANALOG_TWO:   rd_mux = shown[CH_ANALOG_TWO][9:2];
      ADDR_SUPPLY:       rd_mux = shown[CH_SUPPLY][9:2];
      ADDR_FAR_DIODE:    rd_mux = shown[CH_FAR_DIODE][9:2];
      ADDR_ONCHIP:       rd_mux = shown[CH_ONCHIP][9:2];
      ADDR_HOT_TIMER:    rd_mux = hot_value;
      ADDR_INT_STAT_ONE: begin
        rd_mux[STAT1_FAN_B_BIT] = stall_reg;
      end
      default:           rd_mux = READ_RESET;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_data <= READ_RESET;
    end else if (req.rd) begin
      rd_data <= rd_mux;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= req.rd;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_ext_one_pack:
    assert property (rd_ext_one |=> rd_data == {$past(shown[CH_ANALOG_ONE][1:0]),
      $past(shown[CH_ANALOG_TWO][1:0]), $past(shown[CH_SUPPLY][1:0]),
      $past(shown[CH_FAR_DIODE][1:0])})
    else $error("ext one packing wrong");

  a_ext_two_low:
    assert property (rd_ext_two |=> rd_data[1:0] == $past(shown[CH_ONCHIP][1:0]))
    else $error("ext two low bits wrong");

  a_ext_two_zero:
    assert property (rd_ext_two |=> rd_data[7:2] == 6'h00)
    else $error("ext two upper bits not zero");

  a_volt_freeze_hold:
    assert property (rd_ext_one ##1 (volt_frozen && !req.rd)
      |=> $stable(shown[CH_SUPPLY]) && $stable(shown[CH_ANALOG_ONE]))
    else $error("voltage group changed while frozen");

  a_ext_read_hold:
    assert property (rd_ext_one |=> $stable(shown[CH_SUPPLY]) && $stable(shown[CH_FAR_DIODE]))
    else $error("reading moved on the extended read edge");

  a_temp_freeze_set:
    assert property ((rd_ext_one || rd_ext_two) |=> temp_frozen && temp_pend_reg == 2'h3)
    else $error("temperature group not frozen");

  a_volt_msb_read:
    assert property (req.rd && req.addr == ADDR_SUPPLY
      |=> rd_data == $past(shown[CH_SUPPLY][9:2]) && rd_valid)
    else $error("supply upper byte wrong");

  a_temp_msb_read:
    assert property (req.rd && req.addr == ADDR_ONCHIP
      |=> rd_data == $past(shown[CH_ONCHIP][9:2]))
    else $error("on-chip upper byte wrong");

  a_timer_upper_zero:
    assert property (rd_hot && tmr_reg < THRESH_STEPS |=> rd_data[7:1] == 7'h00)
    else $error("timer upper bits early");

  a_hot_seen_set:
    assert property (hot_rise |=> seen_reg [*1] ##0 tmr_reg == 8'h00)
    else $error("assertion flag not set");

  a_hot_read_clear:
    assert property (rd_hot && !hot_rise |=> !seen_reg)
    else $error("read did not clear flag");

  a_timer_count_view:
    assert property (rd_hot && tmr_reg >= THRESH_STEPS |=> rd_data == $past(tmr_reg))
    else $error("timer count not shown");

  a_timer_step:
    assert property (step_tick && tmr_reg != TMR_MAX |=> tmr_reg == $past(tmr_reg) + 8'h01)
    else $error("timer step wrong");

  a_stall_set:
    assert property (stall_cond |=> stall_reg)
    else $error("stall flag not set");

  a_stall_drive_off:
    assert property (!stall_reg && !fan_b_pwm_out |=> !stall_reg)
    else $error("stall flag set with drive off");

  a_timer_saturate:
    assert property (tmr_reg == TMR_MAX && !hot_rise |=> tmr_reg == TMR_MAX)
    else $error("timer wrapped");

  a_volt_release:
    assert property (volt_pend_reg == 3'h4 && req.rd && req.addr == ADDR_SUPPLY
      |=> !volt_frozen)
    else $error("voltage group stayed frozen");

endmodule : monitor_readout_regs
`default_nettype wire

// ==== tb/host_reader.sv ====
// host side model: one-cycle register read and write strobes
`timescale 1ns/1ps
`default_nettype none
module host_reader
  import monitor_readout_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // register access
  output var  host_req_t  req,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  initial begin
    req = '0;
  end

  // ok stays low if no answer came within the bound
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    ok   = 1'b0;
    data = 8'h00;
    @(negedge mclk);
    req.rd   = 1'b1;
    req.addr = addr;
    @(negedge mclk);
    req.rd   = 1'b0;
    // stale address must not matter once taken
    req.addr = ~addr;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rd_valid === 1'b1) begin
        data = rd_data;
        ok   = 1'b1;
      end else begin
        @(negedge mclk);
      end
    end
  endtask : rd

  task automatic wr(input logic [7:0] addr, input logic [7:0] wdata);
    @(negedge mclk);
    req.wr    = 1'b1;
    req.addr  = addr;
    req.wdata = wdata;
    @(negedge mclk);
    req.wr    = 1'b0;
    req.addr  = ~addr;
    req.wdata = ~wdata;
  endtask : wr
endmodule : host_reader
`default_nettype wire

// ==== tb/monitor_readout_regs_bench.sv ====
// self-checking bench of the monitor readout register bank
`timescale 1ns/1ps
`default_nettype none
module monitor_readout_regs_bench;
  import monitor_readout_pkg::*;
  localparam int STEP = 8;
  localparam logic [9:0] CONV [CH_COUNT] = '{10'h2a5, 10'h1c6, 10'h3ff, 10'h101, 10'h0b2};
  localparam logic [7:0] ROW_ADDR [11] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
                                          8'h0e, 8'h0f, 8'h10, 8'h06, 8'h20};
  localparam logic [7:0] ROW_EXP [11]  = '{8'h6d, 8'h02, 8'ha9, 8'h71, 8'hff, 8'h40,
                                          8'h2c, 8'h00, 8'h00, 8'h0c, 8'h00};
  logic                        mclk;
  logic                        rstn;
  host_req_t                   req;
  logic [7:0]                  rd_data;
  logic                        rd_valid;
  conv_result_t [CH_COUNT-1:0] conv_in;
  logic                        hot;
  logic                        stall;
  logic                        pwm;
  logic [7:0]                  fan_b_cfg;
  logic [7:0]                  got;
  logic                        ok;
  int                          errors;
  int                          samples_checked;

  monitor_readout_regs #(.STEP_CYCLES(STEP)) monitor_readout_regs_i (
    .mclk(mclk), .rstn(rstn), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .conv_in(conv_in), .processor_hot_input(hot), .fan_b_stall(stall),
    .fan_b_pwm_out(pwm), .fan_b_cfg(fan_b_cfg));

  host_reader host_reader_i (
    .mclk(mclk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("checked %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    host_reader_i.rd(addr, got, ok);
    if (ok !== 1'b1) begin
      errors++;
      $display("Error read answer at %h expected 1 seen 0", addr);
      end_sim();
    end else begin
      chk($sformatf("reg %h", addr), exp, got);
    end
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic conv_set(input int ch, input logic [9:0] d);
    @(negedge mclk);
    conv_in[ch].valid = 1'b1;
    conv_in[ch].data  = d;
    @(negedge mclk);
    conv_in[ch].valid = 1'b0;
  endtask : conv_set

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    conv_in = '0;
    hot = 1'b0;
    stall = 1'b0;
    pwm = 1'b0;
    errors = 0;
    samples_checked = 0;
    cyc(6);
    rstn = 1'b1;
    chk("fan_b_cfg", 8'h0c, fan_b_cfg);
    rchk(8'h0d, 8'h00);
    for (int c = 0; c < CH_COUNT; c++) conv_set(c, CONV[c]);
    for (int r = 0; r < 11; r++) rchk(ROW_ADDR[r], ROW_EXP[r]);
    // freeze: new results must stay hidden until every upper byte of their group was read
    rchk(8'h08, 8'h6d);
    conv_set(CH_ANALOG_ONE, 10'h000);
    conv_set(CH_FAR_DIODE, 10'h3fc);
    rchk(8'h0a, 8'ha9);
    rchk(8'h0b, 8'h71);
    rchk(8'h0c, 8'hff);
    rchk(8'h0d, 8'h40);
    rchk(8'h0e, 8'h2c);
    rchk(8'h0a, 8'h00);
    rchk(8'h0d, 8'hff);
    rchk(8'h09, 8'h02);
    conv_set(CH_ONCHIP, 10'h3ff);
    rchk(8'h0e, 8'h2c);
    rchk(8'h0d, 8'hff);
    rchk(8'h0e, 8'hff);
    // a result landing on the edge that takes the extended read stays hidden
    fork
      conv_set(CH_SUPPLY, 10'h2fe);
      rchk(8'h08, 8'h2c);
    join
    rchk(8'h0c, 8'hff);
    rchk(8'h0a, 8'h00);
    rchk(8'h0b, 8'h71);
    rchk(8'h0c, 8'hbf);
    rchk(8'h0d, 8'hff);
    rchk(8'h0e, 8'hff);
    // hot timer; read instants chosen mid-step to tolerate one cycle of skew
    hot = 1'b1;
    cyc(1);
    rchk(8'h0f, 8'h01);
    rchk(8'h0f, 8'h00);
    cyc(5);
    rchk(8'h0f, 8'h00);
    cyc(7);
    rchk(8'h0f, 8'h02);
    cyc(2100);
    rchk(8'h0f, 8'hff);
    hot = 1'b0;
    cyc(20);
    rchk(8'h0f, 8'hff);
    // rise on the edge that takes the timer read: the flag survives the read
    fork
      begin
        @(negedge mclk);
        hot = 1'b1;
      end
      rchk(8'h0f, 8'hff);
    join
    rchk(8'h0f, 8'h01);
    hot = 1'b0;
    // fan stall
    stall = 1'b1;
    cyc(2);
    rchk(8'h10, 8'h00);
    pwm = 1'b1;
    cyc(2);
    rchk(8'h10, 8'h01);
    stall = 1'b0;
    rchk(8'h10, 8'h01);
    rchk(8'h10, 8'h00);
    // writes: only the fan config register takes them
    host_reader_i.wr(8'h06, 8'h5a);
    chk("fan_b_cfg", 8'h5a, fan_b_cfg);
    rchk(8'h06, 8'h5a);
    host_reader_i.wr(8'h0b, 8'h33);
    rchk(8'h0b, 8'h71);
    // reset in mid-run
    @(negedge mclk);
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    chk("fan_b_cfg", 8'h0c, fan_b_cfg);
    rchk(8'h0b, 8'h00);
    rchk(8'h0f, 8'h00);
    end_sim();
  end
endmodule : monitor_readout_regs_bench
`default_nettype wire
